/* File: rtl/daq_sample_count_sequencer.v */
// acquisition sequencer: interval pacing, sample counting, result store and register slave
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "daq_seq_defines.vh"
module daq_sample_count_sequencer (
  input  wire                  clock_i,
  input  wire                  rst_b_i,
  input  wire [5:0]            address_i,
  input  wire                  read_i,
  input  wire                  write_i,
  input  wire [31:0]           writedata_i,
  input  wire [3:0]            byteenable_i,
  output reg  [31:0]           readdata_o,
  output reg                   waitrequest_o,
  input  wire                  start_trigger_n_i,
  input  wire                  stop_trigger_i,
  input  wire                  conv_done_i,
  input  wire [`RESULT_W-1:0]  conv_data_i,
  output reg                   conv_start_o,
  output reg  [1:0]            gain_o,
  output reg  [3:0]            channel_o,
  output reg                   running_o
);

  localparam ST_IDLE = 2'b01;
  localparam ST_RUN  = 2'b10;

  // ========================================================================
  // declarations
  reg  [1:0]            state_r;
  reg  [1:0]            state_nxt;
  reg  [2:0]            ctrl_r;
  reg  [15:0]           interval_load_r;
  reg  [15:0]           cnt4_load_r;
  reg  [15:0]           cnt5_load_r;
  reg  [15:0]           cnt4_r;
  reg  [15:0]           cnt5_r;
  reg  [15:0]           interval_r;
  reg                   overflow_r;
  reg                   overrun_r;
  reg                   busy_r;
  reg                   stop_seen_r;
  reg                   ready_r;
  reg  [1:0]            wait_cnt_r;
  reg  [2:0]            start_sync_r;
  reg  [2:0]            stop_sync_r;
  reg  [31:0]           rdata_nxt;
  wire                  req;
  wire                  accept;
  wire                  wr_acc;
  wire                  rd_acc;
  wire                  clear_wr;
  wire                  soft_start;
  wire                  hard_start;
  wire                  trigger;
  wire                  stop_rise;
  wire                  sample_tick;
  wire                  counting;
  wire                  cnt4_hits_zero;
  wire                  cnt5_hits_zero;
  wire                  run_done;
  wire                  overflow_evt;
  wire                  overrun_evt;
  wire                  halt;
  wire                  fifo_full;
  wire                  fifo_empty;
  wire [`RESULT_W-1:0]  fifo_head;

  // ========================================================================
  // bus handshake: fixed wait, then one cycle with waitrequest low
  assign req    = read_i | write_i;
  assign accept = req & ~waitrequest_o;
  assign wr_acc = accept & write_i;
  assign rd_acc = accept & read_i;

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_cnt_r    <= 2'h0;
      waitrequest_o <= 1'b1;
    end else if (accept) begin
      wait_cnt_r    <= 2'h0;
      waitrequest_o <= 1'b1;
    end else if (req) begin
      if (wait_cnt_r == `BUS_WAIT_CYCLES - 2'h1) begin
        waitrequest_o <= 1'b0;
      end
      wait_cnt_r <= wait_cnt_r + 2'h1;
    end else begin
      wait_cnt_r    <= 2'h0;
      waitrequest_o <= 1'b1;
    end
  end

  assign clear_wr   = wr_acc & (address_i == `OFS_CLEAR);
  // only a write whose low sixteen bits are enabled and zero counts as a start
  assign soft_start = wr_acc & (address_i == `OFS_START) &
                      (byteenable_i[1:0] == 2'h3) & (writedata_i[15:0] == 16'h0000);

  // ========================================================================
  // read data, captured while waitrequest is still high
  always @* begin
    rdata_nxt = 32'h0000_0000;
    case (address_i)
      `OFS_CTRL: begin
        rdata_nxt[2:0] = ctrl_r;
      end
      `OFS_MUX_GAIN: begin
        rdata_nxt[`GAIN_HI_BIT:`GAIN_LO_BIT] = gain_o;
        rdata_nxt[`CHAN_HI_BIT:`CHAN_LO_BIT] = channel_o;
      end
      `OFS_STATUS: begin
        rdata_nxt[`STAT_READY_BIT]     = ready_r;
        rdata_nxt[`STAT_OVERFLOW_BIT]  = overflow_r;
        rdata_nxt[`STAT_OVERRUN_BIT]   = overrun_r;
        rdata_nxt[`STAT_RUNNING_BIT]   = running_o;
        rdata_nxt[`STAT_STOP_SEEN_BIT] = stop_seen_r;
      end
      `OFS_FIFO: begin
        rdata_nxt[`RESULT_W-1:0] = fifo_empty ? {`RESULT_W{1'b0}} : fifo_head;
      end
      `OFS_INTERVAL: begin
        rdata_nxt[15:0] = interval_load_r;
      end
      `OFS_CNT4_LOAD: begin
        rdata_nxt[15:0] = cnt4_r;
      end
      `OFS_CNT5_LOAD: begin
        rdata_nxt[15:0] = cnt5_r;
      end
      default: begin
        rdata_nxt = 32'h0000_0000;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      readdata_o <= 32'h0000_0000;
    end else if (read_i & waitrequest_o) begin
      readdata_o <= rdata_nxt;
    end
  end

  // ========================================================================
  // software registers
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrl_r          <= `CTRL_RST;
      gain_o          <= 2'h0;
      channel_o       <= 4'h0;
      interval_load_r <= `INTERVAL_RST;
      cnt4_load_r     <= `CNT_RST;
      cnt5_load_r     <= `CNT_RST;
    end else if (wr_acc) begin
      case (address_i)
        `OFS_CTRL: begin
          ctrl_r <= writedata_i[2:0];
        end
        `OFS_MUX_GAIN: begin
          gain_o    <= writedata_i[`GAIN_HI_BIT:`GAIN_LO_BIT];
          channel_o <= writedata_i[`CHAN_HI_BIT:`CHAN_LO_BIT];
        end
        `OFS_INTERVAL: begin
          interval_load_r <= writedata_i[15:0];
        end
        `OFS_CNT4_LOAD: begin
          cnt4_load_r <= writedata_i[15:0];
        end
        `OFS_CNT5_LOAD: begin
          cnt5_load_r <= writedata_i[15:0];
        end
        default: begin
          ctrl_r <= ctrl_r;
        end
      endcase
    end
  end

  // ========================================================================
  // trigger pins: two flops, then a third for the edge
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      start_sync_r <= 3'h7;
      stop_sync_r  <= 3'h0;
    end else begin
      start_sync_r <= {start_sync_r[1:0], start_trigger_n_i};
      stop_sync_r  <= {stop_sync_r[1:0], stop_trigger_i};
    end
  end

  assign hard_start = start_sync_r[2] & ~start_sync_r[1];
  assign stop_rise  = ~stop_sync_r[2] & stop_sync_r[1];
  assign trigger    = (soft_start | hard_start) & ctrl_r[`CTRL_ACQ_EN_BIT];

  // ========================================================================
  // run sequencing
  assign sample_tick    = (state_r == ST_RUN) & (interval_r == 16'h0001) & ~halt;
  // pretrigger mode gates the sample counter until the stop trigger rises
  assign counting       = sample_tick & (~ctrl_r[`CTRL_PRETRIG_BIT] | stop_seen_r);
  assign cnt4_hits_zero = counting & (cnt4_r == 16'h0001);
  assign cnt5_hits_zero = cnt4_hits_zero & (cnt5_r == 16'h0001);
  assign run_done       = ctrl_r[`CTRL_WIDTH_BIT] ? cnt5_hits_zero : cnt4_hits_zero;
  assign overflow_evt   = conv_done_i & fifo_full & ~clear_wr;
  assign overrun_evt    = (state_r == ST_RUN) & (interval_r == 16'h0001) & busy_r;
  assign halt           = overflow_evt | overrun_evt;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (trigger) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (halt | run_done) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r      <= ST_IDLE;
      running_o    <= 1'b0;
      conv_start_o <= 1'b0;
      busy_r       <= 1'b0;
      stop_seen_r  <= 1'b0;
      interval_r   <= `INTERVAL_RST;
    end else begin
      state_r      <= state_nxt;
      running_o    <= (state_nxt == ST_RUN);
      conv_start_o <= sample_tick & ~busy_r;
      if (sample_tick & ~busy_r) begin
        busy_r <= 1'b1;
      end else if (conv_done_i) begin
        busy_r <= 1'b0;
      end
      if (state_r == ST_IDLE) begin
        stop_seen_r <= 1'b0;
      end else if (stop_rise) begin
        stop_seen_r <= 1'b1;
      end
      // zero in the interval load stands for 65536 by wrapping
      if ((state_r != ST_RUN) | (interval_r == 16'h0001)) begin
        interval_r <= interval_load_r;
      end else begin
        interval_r <= interval_r - 16'h0001;
      end
    end
  end

  // ========================================================================
  // sample counters; a write to a load register loads the counter too
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt4_r <= `CNT_RST;
      cnt5_r <= `CNT_RST;
    end else if (wr_acc & (address_i == `OFS_CNT4_LOAD)) begin
      cnt4_r <= writedata_i[15:0];
    end else if (wr_acc & (address_i == `OFS_CNT5_LOAD)) begin
      cnt5_r <= writedata_i[15:0];
    end else if (run_done) begin
      // reload both so the next trigger repeats the run
      cnt4_r <= cnt4_load_r;
      cnt5_r <= cnt5_load_r;
    end else if (cnt4_hits_zero) begin
      cnt4_r <= cnt4_load_r;
      if (ctrl_r[`CTRL_WIDTH_BIT]) begin
        cnt5_r <= cnt5_r - 16'h0001;
      end
    end else if (counting) begin
      cnt4_r <= cnt4_r - 16'h0001;
    end
  end

  // ========================================================================
  // error flags; an overrun in the clearing cycle still sets its flag, an overflow is masked by the clear
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      overflow_r <= 1'b0;
      overrun_r  <= 1'b0;
      ready_r    <= 1'b0;
    end else begin
      if (overflow_evt) begin
        overflow_r <= 1'b1;
      end else if (clear_wr) begin
        overflow_r <= 1'b0;
      end
      if (overrun_evt) begin
        overrun_r <= 1'b1;
      end else if (clear_wr) begin
        overrun_r <= 1'b0;
      end
      ready_r <= ~fifo_empty;
    end
  end

  // ========================================================================
  // result store; a result finishing during a clear is dropped with the rest
  result_fifo u_result_fifo (
    .clock_i     (clock_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (clear_wr),
    .push_i      (conv_done_i),
    .push_data_i (conv_data_i),
    .pop_i       (rd_acc & (address_i == `OFS_FIFO)),
    .head_data_o (fifo_head),
    .full_o      (fifo_full),
    .empty_o     (fifo_empty)
  );

endmodule

/* File: rtl/daq_seq_defines.vh */
// register map, field positions, reset values and widths of the acquisition sequencer
`ifndef DAQ_SEQ_DEFINES_VH
`define DAQ_SEQ_DEFINES_VH

// ==========================================================================
// register byte offsets
`define OFS_CTRL        6'h00
`define OFS_MUX_GAIN    6'h04
`define OFS_STATUS      6'h08
`define OFS_FIFO        6'h0c
`define OFS_CLEAR       6'h10
`define OFS_START       6'h14
`define OFS_INTERVAL    6'h18
`define OFS_CNT4_LOAD   6'h1c
`define OFS_CNT5_LOAD   6'h20

// ==========================================================================
// control register fields
`define CTRL_ACQ_EN_BIT    0
`define CTRL_WIDTH_BIT     1
`define CTRL_PRETRIG_BIT   2
`define CTRL_RST           3'h0

// ==========================================================================
// channel and gain register fields
`define GAIN_HI_BIT        7
`define GAIN_LO_BIT        6
`define CHAN_HI_BIT        3
`define CHAN_LO_BIT        0
`define MUX_GAIN_RST       6'h00

// ==========================================================================
// status register fields
`define STAT_READY_BIT     13
`define STAT_OVERFLOW_BIT  12
`define STAT_OVERRUN_BIT   11
`define STAT_RUNNING_BIT   10
`define STAT_STOP_SEEN_BIT 9

// ==========================================================================
// counters and result storage
`define CNT_RST            16'h0000
`define INTERVAL_RST       16'h0002
`define FIFO_DEPTH         512
`define FIFO_AW            9
`define RESULT_W           16

// ==========================================================================
// bus answer timing: cycles of waitrequest before the answer
`define BUS_WAIT_CYCLES    2'h2

`endif

/* File: rtl/result_fifo.v */
// result store: 512 by 16 first-in first-out memory with registered read data
`timescale 1ns/1ps
`include "daq_seq_defines.vh"
module result_fifo (
  input  wire                       clock_i,
  input  wire                       rst_b_i,
  input  wire                       flush_i,
  input  wire                       push_i,
  input  wire [`RESULT_W-1:0]       push_data_i,
  input  wire                       pop_i,
  output reg  [`RESULT_W-1:0]       head_data_o,
  output wire                       full_o,
  output wire                       empty_o
);

  reg [`RESULT_W-1:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW-1:0]  wr_ptr_r;
  reg [`FIFO_AW-1:0]  rd_ptr_r;
  reg [`FIFO_AW:0]    count_r;
  wire                do_push;
  wire                do_pop;

  // depth is a power of two, so the top count bit alone marks full
  assign full_o  = count_r[`FIFO_AW];
  assign empty_o = (count_r == {(`FIFO_AW+1){1'b0}});
  // a flush drops any push or pop of the same cycle
  assign do_push = push_i & ~full_o & ~flush_i;
  assign do_pop  = pop_i & ~empty_o & ~flush_i;

  // ========================================================================
  // storage; head is one cycle behind the pointer, the bus allows for it
  always @(posedge clock_i) begin
    if (do_push) begin
      mem[wr_ptr_r] <= push_data_i;
    end
    head_data_o <= mem[rd_ptr_r];
  end

  // ========================================================================
  // pointers, oldest entry leaves first
  always @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_ptr_r <= {`FIFO_AW{1'b0}};
      rd_ptr_r <= {`FIFO_AW{1'b0}};
      count_r  <= {(`FIFO_AW+1){1'b0}};
    end else if (flush_i) begin
      wr_ptr_r <= {`FIFO_AW{1'b0}};
      rd_ptr_r <= {`FIFO_AW{1'b0}};
      count_r  <= {(`FIFO_AW+1){1'b0}};
    end else begin
      if (do_push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
      if (do_push & ~do_pop) begin
        count_r <= count_r + 1'b1;
      end else if (do_pop & ~do_push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

endmodule

/* File: test/daq_seq_props.sv */
// checker of bus timing, conversion pulses and register outputs of the sequencer
`timescale 1ns/1ps
module daq_seq_props (
  input wire logic        clock_i,
  input wire logic        rst_b_i,
  input wire logic [5:0]  address_i,
  input wire logic        read_i,
  input wire logic        write_i,
  input wire logic [31:0] writedata_i,
  input wire logic [31:0] readdata_o,
  input wire logic        waitrequest_o,
  input wire logic        conv_start_o,
  input wire logic [1:0]  gain_o,
  input wire logic [3:0]  channel_o,
  input wire logic        running_o
);
  wire req;
  wire done;
  assign req  = read_i | write_i;
  assign done = req & ~waitrequest_o;

  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);

  // ==========================================================================
  // bus handshake
  sequence s_req_start;
    $rose(req);
  endsequence
  sequence s_answer;
    waitrequest_o ##1 !waitrequest_o ##1 waitrequest_o;
  endsequence
  AST_WAIT_ANSWER: assert property (s_req_start |-> waitrequest_o ##1 s_answer)
    else $error("bus answer not two cycles after request");
  AST_IDLE_WAIT: assert property (!req |-> waitrequest_o)
    else $error("waitrequest low without request");
  AST_UNMAPPED: assert property (done && read_i && address_i > 6'h20 |-> readdata_o == 32'h0)
    else $error("unmapped read not zero");

  // ==========================================================================
  // acquisition outputs
  AST_START_PULSE: assert property (conv_start_o |=> !conv_start_o)
    else $error("conversion request longer than one cycle");
  AST_START_RUN: assert property (conv_start_o |-> $past(running_o))
    else $error("conversion request outside a run");
  AST_STATUS: assert property (done && read_i && address_i == 6'h08 |->
    readdata_o[10] == $past(running_o) && readdata_o[31:14] == 18'h0)
    else $error("status read inconsistent");
  AST_GAIN: assert property ($changed(gain_o) |->
    $past(done && write_i && address_i == 6'h04) && gain_o == $past(writedata_i[7:6]))
    else $error("gain changed without register write");
  AST_CHAN: assert property ($changed(channel_o) |->
    $past(done && write_i && address_i == 6'h04) && channel_o == $past(writedata_i[3:0]))
    else $error("channel changed without register write");
endmodule

bind daq_sample_count_sequencer daq_seq_props u_props (
  .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
  .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
  .waitrequest_o(waitrequest_o), .conv_start_o(conv_start_o), .gain_o(gain_o),
  .channel_o(channel_o), .running_o(running_o));

/* File: test/tb_top.sv */
// self-checking testbench of the acquisition sequencer
`timescale 1ns/1ps
module tb_top;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic [5:0]  address_i = 6'h00;
  logic        read_i = 1'b0;
  logic        write_i = 1'b0;
  logic [31:0] writedata_i = 32'h0;
  logic [3:0]  byteenable_i = 4'hf;
  logic        start_trigger_n_i = 1'b1;
  logic        stop_trigger_i = 1'b0;
  logic        conv_done_i = 1'b0;
  logic [15:0] conv_data_i = 16'h0;
  wire  [31:0] readdata_o;
  wire         waitrequest_o;
  wire         conv_start_o;
  wire  [1:0]  gain_o;
  wire  [3:0]  channel_o;
  wire         running_o;
  int          num_errors = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_starts = 0;
  int          gap = 0;
  int          gap_bad = 0;
  int          exp_gap = 5;
  int          conv_dly = 2;
  int          dly_cnt = 0;
  int          n;
  logic [15:0] next_data = 16'h0;
  logic [15:0] base;
  logic [31:0] rd;
  logic [31:0] v;

  daq_sample_count_sequencer dut (
    .clock_i(clock_i), .rst_b_i(rst_b_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
    .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
    .start_trigger_n_i(start_trigger_n_i), .stop_trigger_i(stop_trigger_i),
    .conv_done_i(conv_done_i), .conv_data_i(conv_data_i), .conv_start_o(conv_start_o),
    .gain_o(gain_o), .channel_o(channel_o), .running_o(running_o));

  always #4 clock_i = ~clock_i;

  // ==========================================================================
  // watchdog and converter stand-in
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      num_errors = num_errors + 1;
      summarize();
    end
  end

  // answers each request after conv_dly clocks; a long delay provokes overrun
  always @(posedge clock_i) begin
    conv_done_i <= 1'b0;
    gap <= gap + 1;
    if (conv_start_o === 1'b1) begin
      if (n_starts > 0 && gap + 1 != exp_gap) gap_bad <= gap_bad + 1;
      n_starts <= n_starts + 1;
      gap <= 0;
      dly_cnt <= conv_dly;
    end else if (dly_cnt == 1) begin
      conv_done_i <= 1'b1;
      conv_data_i <= next_data;
      next_data <= next_data + 16'h1;
      dly_cnt <= 0;
    end else if (dly_cnt > 1) begin
      dly_cnt <= dly_cnt - 1;
    end
  end

  // ==========================================================================
  // tasks
  task check(input logic [31:0] s, input logic [31:0] e);
    cmp_count = cmp_count + 1;
    if (s !== e) begin
      num_errors = num_errors + 1;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task summarize;
    $display("errors=%0d compares=%0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // request held until the edge at which waitrequest is seen low
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    @(posedge clock_i);
    address_i <= a;
    writedata_i <= d;
    byteenable_i <= be;
    write_i <= w;
    read_i <= ~w;
    do @(posedge clock_i); while (waitrequest_o !== 1'b0);
    rd = readdata_o;
    write_i <= 1'b0;
    read_i <= 1'b0;
  endtask

  task wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task rdc(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    check(rd, e);
  endtask

  task pin_pulse;
    start_trigger_n_i <= 1'b0;
    repeat (4) @(posedge clock_i);
    start_trigger_n_i <= 1'b1;
  endtask

  task wait_end;
    int k;
    k = 0;
    while (running_o !== 1'b1 && k < 40) begin
      @(posedge clock_i);
      k++;
    end
    check(running_o, 1'b1);
    while (running_o !== 1'b0) @(posedge clock_i);
    // the last request shows together with the run end; let the stand-in count it
    @(posedge clock_i);
  endtask

  // clear, then trigger by upper-half-dirty soft start or by the pin
  task run(input logic [31:0] ctrl, input int ex, input logic pin);
    n_starts = 0;
    gap_bad = 0;
    wr(6'h00, ctrl);
    wr(6'h10, 32'h0);
    if (pin) pin_pulse();
    else wr(6'h14, 32'hffff0000);
    wait_end();
    check(n_starts, ex);
    check(gap_bad, 0);
  endtask

  task drain(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      bus(1'b0, 6'h08, 32'h0, 4'hf);
      check(rd[13], 1'b1);
      rdc(6'h0c, {16'h0, base + i[15:0]});
    end
    bus(1'b0, 6'h08, 32'h0, 4'hf);
    check(rd[13], 1'b0);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(32'h91f6d018));
    repeat (16) @(posedge clock_i);
    rst_b_i <= 1'b1;
    rdc(6'h00, 32'h0);
    rdc(6'h04, 32'h0);
    rdc(6'h08, 32'h0);
    rdc(6'h0c, 32'h0);
    rdc(6'h18, 32'h2);
    rdc(6'h3c, 32'h0);
    check({gain_o, channel_o, running_o}, 7'h0);
    repeat (8) begin
      v = $urandom;
      wr(6'h04, v);
      @(posedge clock_i);
      check({gain_o, channel_o}, {v[7:6], v[3:0]});
      rdc(6'h04, v & 32'hcf);
    end
    wr(6'h00, 32'h0);
    wr(6'h14, 32'h0);
    pin_pulse();
    repeat (10) @(posedge clock_i);
    check(running_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      n = (i == 0) ? 2 : 2 + $urandom % 6;
      exp_gap = 5 + $urandom % 5;
      wr(6'h18, exp_gap);
      wr(6'h1c, n);
      base = $urandom;
      next_data = base;
      run(32'h1, n, i[0]);
      drain(n);
      rdc(6'h1c, n);
    end
    wr(6'h00, 32'h1);
    bus(1'b1, 6'h14, 32'h1, 4'hf);
    bus(1'b1, 6'h14, 32'h0, 4'h1);
    repeat (10) @(posedge clock_i);
    check(running_o, 1'b0);
    wr(6'h1c, 32'h3);
    wr(6'h20, 32'h2);
    base = $urandom;
    next_data = base;
    run(32'h3, 6, 1'b0);
    drain(6);
    rdc(6'h20, 32'h2);
    conv_dly = 40;
    wr(6'h1c, 32'h4);
    run(32'h1, 1, 1'b0);
    repeat (50) @(posedge clock_i);
    bus(1'b0, 6'h08, 32'h0, 4'hf);
    check(rd[12:10], 3'b010);
    wr(6'h10, 32'h0);
    rdc(6'h08, 32'h0);
    conv_dly = 2;
    wr(6'h1c, 32'd600);
    run(32'h1, 513, 1'b0);
    bus(1'b0, 6'h08, 32'h0, 4'hf);
    check(rd[13:10], 4'b1100);
    wr(6'h10, 32'h0);
    rdc(6'h08, 32'h0);
    rdc(6'h0c, 32'h0);
    wr(6'h1c, 32'h2);
    n_starts = 0;
    wr(6'h00, 32'h5);
    wr(6'h14, 32'h0);
    while (n_starts < 5) @(posedge clock_i);
    check(running_o, 1'b1);
    stop_trigger_i <= 1'b1;
    wait_end();
    stop_trigger_i <= 1'b0;
    wr(6'h10, 32'h0);
    rdc(6'h08, 32'h0);
    summarize();
  end
endmodule
